/* src/lcd_cmd_pkg.sv */
// Package: bus codes, status layout and sizes for the LCD host command block.
// Assumes a single synchronous clock domain in the user of it.
package lcd_cmd_pkg;
  localparam logic [7:0] CODE_DUTY = 8'hA8;
  localparam logic [7:0] CODE_DUTY_MASK = 8'hFE;
  localparam logic [7:0] CODE_MAP = 8'hA0;
  localparam logic [7:0] CODE_DISP = 8'hAE;
  localparam logic [7:0] CODE_PAGE = 8'hB8;
  localparam logic [7:0] CODE_PAGE_MASK = 8'hFC;
  localparam logic [7:0] CODE_COL_MASK = 8'h80;
  localparam logic [7:0] CODE_RMW = 8'hE0;
  localparam logic [7:0] CODE_END = 8'hEE;
  localparam logic [7:0] CODE_SWRESET = 8'hE2;
  localparam int STAT_BUSY = 7;
  localparam int STAT_MAP = 6;
  localparam int STAT_OFF = 5;
  localparam int STAT_RESET = 4;
  localparam logic [3:0] STAT_LOW_ZERO = 4'h0;
  localparam int PAGES = 4;
  localparam int COLUMNS = 80;
  localparam logic [6:0] COL_LAST = 7'h4F;
  localparam logic [6:0] COL_ZERO = 7'h00;
  localparam logic [1:0] PAGE_SWRESET = 2'h3;
  localparam logic [4:0] LINE_ZERO = 5'h00;
  localparam int RESET_BUSY_CYCLES = 16;
  localparam int CMD_BUSY_CYCLES = 2;
  localparam logic [4:0] DUTY_ROWS_16 = 5'h0F;
  localparam logic [4:0] DUTY_ROWS_32 = 5'h1F;
endpackage

/* src/lcd_row_scan.sv */
// Row scan counter: wraps at 16 or 32 rows per frame.
// Assumes line_clock and frame_signal already synchronised to clock_in.
`timescale 1ns/1ps
`default_nettype none
module lcd_row_scan
  import lcd_cmd_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic duty32_in,
  input wire logic line_step_in,
  input wire logic frame_start_in,
  output logic [4:0] row_out
);
  logic [4:0] last_row;

  // Segment-only builds keep duty32 low; the master's frame restarts rows
  assign last_row = duty32_in ? DUTY_ROWS_32 : DUTY_ROWS_16;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      row_out <= 5'h00;
    else if (frame_start_in)
      row_out <= 5'h00;
    else if (line_step_in)
      row_out <= (row_out == last_row) ? 5'h00 : row_out + 5'h01;
  end
endmodule
`default_nettype wire

/* src/lcd_host_command_status.sv */
// Host command, status and display memory port of the LCD driver.
// Assumes bus strobes from pins, synchronised here; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_command_status
  import lcd_cmd_pkg::*;
#(
  parameter bit SEGMENT_ONLY = 1'b0
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cmd_data_sel_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic frame_signal_in,
  input wire logic line_clock_in,
  output logic duty32_out,
  output logic map_inverted_out,
  output logic display_on_out,
  output logic [4:0] start_line_out,
  output logic [4:0] row_out,
  output logic busy_out
);
  logic [1:0] sel_sync_reg, rd_sync_reg, wr_sync_reg, fr_sync_reg, cl_sync_reg;
  logic [7:0] data_s1_reg, data_s2_reg;
  logic rd_prev_reg, wr_prev_reg, fr_prev_reg, cl_prev_reg;
  logic rd_edge, wr_edge, ctrl_wr, data_wr, ctrl_rd, data_rd;
  logic duty_reg, map_reg, disp_reg, rmw_reg;
  logic [4:0] line_reg;
  logic [1:0] page_reg;
  logic [6:0] col_reg, col_saved_reg, col_inc;
  logic [7:0] latch_reg;
  logic [7:0] mem_reg [PAGES*COLUMNS];
  logic [4:0] busy_cnt_reg;
  logic in_reset_reg;
  logic [8:0] mem_idx;

  // Pins cross into the clock domain through two flops each
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sel_sync_reg <= 2'h0;
      rd_sync_reg <= 2'h3;
      wr_sync_reg <= 2'h3;
      fr_sync_reg <= 2'h0;
      cl_sync_reg <= 2'h0;
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      fr_prev_reg <= 1'b0;
      cl_prev_reg <= 1'b0;
    end
    else
    begin
      sel_sync_reg <= {sel_sync_reg[0], cmd_data_sel_in};
      rd_sync_reg <= {rd_sync_reg[0], read_n_in};
      wr_sync_reg <= {wr_sync_reg[0], write_n_in};
      fr_sync_reg <= {fr_sync_reg[0], frame_signal_in};
      cl_sync_reg <= {cl_sync_reg[0], line_clock_in};
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
      rd_prev_reg <= rd_sync_reg[1];
      wr_prev_reg <= wr_sync_reg[1];
      fr_prev_reg <= fr_sync_reg[1];
      cl_prev_reg <= cl_sync_reg[1];
    end
  end

  // Act on strobe falling edge, status read for as long as the strobe is low; a host ignoring busy is simply dropped
  assign rd_edge = rd_prev_reg & ~rd_sync_reg[1] & wr_sync_reg[1];
  assign wr_edge = wr_prev_reg & ~wr_sync_reg[1] & rd_sync_reg[1];
  assign ctrl_wr = wr_edge & ~sel_sync_reg[1] & ~busy_out;
  assign data_wr = wr_edge & sel_sync_reg[1] & ~busy_out;
  assign ctrl_rd = ~rd_sync_reg[1] & wr_sync_reg[1]
    & ~sel_sync_reg[1];
  assign data_rd = rd_edge & sel_sync_reg[1] & ~busy_out;
  assign col_inc = (col_reg == COL_LAST) ? COL_ZERO : col_reg + 7'h01;
  assign mem_idx = 9'(page_reg * COLUMNS) + 9'(col_reg);

  // Busy covers reset and each accepted command
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_cnt_reg <= 5'(RESET_BUSY_CYCLES);
      in_reset_reg <= 1'b1;
    end
    else if (busy_cnt_reg != 5'h00)
      busy_cnt_reg <= busy_cnt_reg - 5'h01;
    else if (ctrl_wr | data_wr | data_rd)
      busy_cnt_reg <= 5'(CMD_BUSY_CYCLES);
    else
      in_reset_reg <= 1'b0;
  end
  assign busy_out = (busy_cnt_reg != 5'h00) | in_reset_reg;

  // Control registers
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      duty_reg <= 1'b0;
      map_reg <= 1'b0;
      disp_reg <= 1'b0;
      line_reg <= LINE_ZERO;
      page_reg <= 2'h0;
    end
    else if (ctrl_wr)
    begin
      if (!SEGMENT_ONLY && (data_s2_reg & CODE_DUTY_MASK) == CODE_DUTY)
        duty_reg <= data_s2_reg[0];
      if ((data_s2_reg & CODE_DUTY_MASK) == CODE_MAP)
        map_reg <= data_s2_reg[0];
      if ((data_s2_reg & CODE_DUTY_MASK) == CODE_DISP)
        disp_reg <= data_s2_reg[0];
      if ((data_s2_reg & CODE_PAGE_MASK) == CODE_PAGE)
        page_reg <= data_s2_reg[1:0];
      if (data_s2_reg == CODE_SWRESET)
      begin
        line_reg <= LINE_ZERO;
        page_reg <= PAGE_SWRESET;
      end
    end
  end

  // Column pointer and read-modify-write
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      col_reg <= COL_ZERO;
      col_saved_reg <= COL_ZERO;
      rmw_reg <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      if ((data_s2_reg & CODE_COL_MASK) == 8'h00
        && data_s2_reg[6:0] <= COL_LAST)
        col_reg <= data_s2_reg[6:0];
      if (data_s2_reg == CODE_RMW)
      begin
        rmw_reg <= 1'b1;
        col_saved_reg <= col_reg;
      end
      if (data_s2_reg == CODE_END && rmw_reg)
      begin
        rmw_reg <= 1'b0;
        col_reg <= col_saved_reg;
      end
    end
    else if (data_wr | (data_rd & ~rmw_reg))
      col_reg <= col_inc;
  end

  // Memory has no reset: its content survives soft reset
  always_ff @(posedge clock_in)
  begin
    if (data_wr)
      mem_reg[mem_idx] <= data_s2_reg;
  end

  // Output latch and bus driver
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      latch_reg <= 8'h00;
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
    end
    else
    begin
      if (data_rd)
      begin
        data_out <= latch_reg;
        latch_reg <= mem_reg[mem_idx];
      end
      else if (ctrl_rd)
        data_out <= {busy_out, map_reg, ~disp_reg, in_reset_reg,
          STAT_LOW_ZERO};
      data_oe_out <= ~rd_sync_reg[1] & wr_sync_reg[1];
    end
  end

  lcd_row_scan u_row_scan (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .duty32_in(duty_reg),
    .line_step_in(cl_sync_reg[1] & ~cl_prev_reg),
    .frame_start_in(fr_sync_reg[1] & ~fr_prev_reg),
    .row_out(row_out)
  );

  assign duty32_out = duty_reg;
  assign map_inverted_out = map_reg;
  assign display_on_out = disp_reg;
  assign start_line_out = line_reg;

  a_duty_load: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_wr && !SEGMENT_ONLY && (data_s2_reg & CODE_DUTY_MASK) == CODE_DUTY
    |=> duty_reg == $past(data_s2_reg[0]))
    else $error("duty bit not loaded");
  a_status_low: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_rd && !data_rd |=> data_out[3:0] == STAT_LOW_ZERO)
    else $error("status low nibble not zero");
  a_busy_cmd: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_wr |=> busy_out [*2])
    else $error("busy not held after command");
  a_status_off: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_rd && !data_rd |=> data_out[STAT_OFF] == ~$past(disp_reg))
    else $error("display off flag wrong");
  a_write_col: assert property (@(posedge clock_in) disable iff (rst_in)
    data_wr |=> col_reg == $past(col_inc))
    else $error("column not advanced on write");
  a_rmw_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    data_rd && rmw_reg |=> $stable(col_reg))
    else $error("column moved on rmw read");
  a_end_restore: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_wr && data_s2_reg == CODE_END && rmw_reg
    |=> col_reg == $past(col_saved_reg) && !rmw_reg)
    else $error("column not restored");
  a_soft_reset: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_wr && data_s2_reg == CODE_SWRESET
    |=> page_reg == PAGE_SWRESET && line_reg == LINE_ZERO)
    else $error("soft reset values wrong");
  a_read_latch: assert property (@(posedge clock_in) disable iff (rst_in)
    data_rd |=> data_out == $past(latch_reg))
    else $error("read did not return old latch");
  a_seg_duty_off: assert property (@(posedge clock_in) disable iff (rst_in)
    SEGMENT_ONLY |-> !duty_reg)
    else $error("duty bit set in segment-only build");
endmodule
`default_nettype wire

/* tb/lcd_host_model.sv */
// Host side model: drives strobes, command select and the data bus.
// Assumes a free-running clock_in and a device answering on data_in.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model
(
  input wire logic clock_in,
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  output logic sel_out,
  output logic read_n_out,
  output logic write_n_out,
  output logic [7:0] data_out
);
  initial
  begin
    sel_out = 1'b0;
    read_n_out = 1'b1;
    write_n_out = 1'b1;
    data_out = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // Strobe held six clocks: the pin path needs three before it acts
  task automatic write_cycle(input logic sel, input logic [7:0] v);
    tick(1);
    sel_out = sel;
    data_out = v;
    write_n_out = 1'b0;
    tick(6);
    write_n_out = 1'b1;
    tick(1);
    data_out = ~v; // Released bus must not keep the last value
    tick(4);
  endtask
  task automatic read_cycle(input logic sel, output logic [7:0] v,
    output logic oe);
    tick(1);
    sel_out = sel;
    read_n_out = 1'b0;
    tick(6);
    v = data_in;
    oe = data_oe_in;
    read_n_out = 1'b1;
    tick(4);
  endtask
  task automatic wait_ready(output logic ok);
    logic [7:0] s;
    logic oe;
    ok = 1'b0;
    repeat (30)
      if (ok !== 1'b1)
      begin
        read_cycle(1'b0, s, oe);
        ok = (s[7] === 1'b0);
      end
  endtask
endmodule
`default_nettype wire

/* tb/lcd_host_command_status_bench.sv */
// Bench: host model drives the block; a behavioural model checks it.
// Assumes the package, the design and the host model compiled first.
`timescale 1ns/1ps
`default_nettype none
`define check_eq(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  fails++; $display("mismatch at %0t: got %h expected %h", $time, got, \
  exp); end end
module lcd_host_command_status_bench import lcd_cmd_pkg::*;;
  logic clock_in, rst_in, sel, rd_n, wr_n, frame, line, oe, duty32;
  logic map_inv, disp_on, busy, seg_duty32;
  logic [4:0] seg_row;
  logic [7:0] bus_w, bus_r;
  logic [4:0] start_line, row;
  int fails, n_tests, seed, page, col, latch, saved, rows, srows, p;
  int mem [4][80];
  bit rmw, map, disp, d32;
  logic [7:0] setup [6] = '{8'hAF, 8'hA1, 8'hA9, 8'hA8, 8'hAE, 8'hA0};
  lcd_host_command_status dut (.clock_in(clock_in), .rst_in(rst_in),
    .cmd_data_sel_in(sel), .read_n_in(rd_n), .write_n_in(wr_n),
    .data_in(bus_w), .data_out(bus_r), .data_oe_out(oe),
    .frame_signal_in(frame), .line_clock_in(line), .duty32_out(duty32),
    .map_inverted_out(map_inv), .display_on_out(disp_on),
    .start_line_out(start_line), .row_out(row), .busy_out(busy));
  lcd_host_model host (.clock_in(clock_in), .data_in(bus_r),
    .data_oe_in(oe), .sel_out(sel), .read_n_out(rd_n),
    .write_n_out(wr_n), .data_out(bus_w));
  lcd_host_command_status #(.SEGMENT_ONLY(1'b1)) dut_seg (
    .clock_in(clock_in), .rst_in(rst_in),
    .cmd_data_sel_in(sel), .read_n_in(rd_n), .write_n_in(wr_n),
    .data_in(bus_w), .data_out(), .data_oe_out(),
    .frame_signal_in(frame), .line_clock_in(line),
    .duty32_out(seg_duty32), .map_inverted_out(), .display_on_out(),
    .start_line_out(), .row_out(seg_row), .busy_out());
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic complete_run;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic cmd(input logic [7:0] c);
    logic ok;
    host.wait_ready(ok);
    `check_eq(ok, 1'b1)
    host.write_cycle(1'b0, c);
    if ((c & CODE_DUTY_MASK) == CODE_DUTY) d32 = c[0];
    if ((c & CODE_DUTY_MASK) == CODE_MAP) map = c[0];
    if ((c & CODE_DUTY_MASK) == CODE_DISP) disp = c[0];
    if ((c & CODE_PAGE_MASK) == CODE_PAGE) page = c[1:0];
    if (c <= 8'h4F) col = c;
    if (c == CODE_RMW) saved = col;
    if (c == CODE_END && rmw) col = saved;
    if (c == CODE_RMW || c == CODE_END) rmw = (c == CODE_RMW);
    if (c == CODE_SWRESET) page = 3;
    `check_eq(duty32, d32)
    `check_eq(seg_duty32, 1'b0)
    `check_eq({map_inv, disp_on}, {map, disp})
  endtask
  task automatic wr(input logic [7:0] v);
    logic ok;
    host.wait_ready(ok);
    `check_eq(ok, 1'b1)
    host.write_cycle(1'b1, v);
    mem[page][col] = v;
    col = (col + 1) % COLUMNS;
  endtask
  task automatic rd;
    logic ok, oe_seen;
    logic [7:0] v;
    host.wait_ready(ok);
    `check_eq(ok, 1'b1)
    host.read_cycle(1'b1, v, oe_seen);
    `check_eq(oe_seen, 1'b1)
    if (latch >= 0) `check_eq(v, 8'(latch))
    latch = mem[page][col];
    if (!rmw) col = (col + 1) % COLUMNS;
  endtask
  task automatic stat(input logic b, input logic r);
    logic oe_seen;
    logic [7:0] v;
    host.read_cycle(1'b0, v, oe_seen);
    `check_eq(v, {b, map, !disp, r, STAT_LOW_ZERO})
  endtask
  task automatic pulse(input bit fr);
    tick(1);
    frame = fr;
    line = !fr;
    tick(4);
    frame = 1'b0;
    line = 1'b0;
    tick(5);
    rows = fr ? 0 : (rows + 1) % (d32 ? 32 : 16);
    `check_eq(row, 5'(rows))
    srows = fr ? 0 : (srows + 1) % 16;
    `check_eq(seg_row, 5'(srows))
  endtask
  initial
  begin
    #200000;
    fails++;
    complete_run();
  end
  initial
  begin
    seed = 42499;
    rst_in = 1'b1;
    frame = 1'b0;
    line = 1'b0;
    latch = -1;
    foreach (mem[i, j]) mem[i][j] = -1;
    tick(5);
    rst_in = 1'b0;
    `check_eq(busy, 1'b1)
    stat(1'b1, 1'b1);
    foreach (setup[k])
    begin
      cmd(setup[k]);
      stat(1'b0, 1'b0);
    end
    foreach (setup[k])
    begin
      cmd(setup[k + 2]);
      pulse(1'b1);
      repeat (40) pulse(1'b0);
      if (k == 1) break;
    end
    for (p = 0; p < PAGES; p++)
    begin
      cmd(CODE_PAGE | 8'(p));
      cmd(8'h4E);
      repeat (3) wr(8'($random(seed)));
      cmd(CODE_PAGE | 8'(p));
      cmd(8'h4E);
      repeat (4) rd();
    end
    cmd(CODE_PAGE | 8'h01);
    cmd(8'h4F);
    rd();
    cmd(CODE_RMW);
    repeat (2) rd();
    repeat (2) wr(8'($random(seed)));
    cmd(CODE_END);
    repeat (3) rd();
    cmd(CODE_PAGE);
    cmd(8'h05);
    cmd(CODE_END);
    cmd(CODE_SWRESET);
    `check_eq(start_line, LINE_ZERO)
    wr(8'($random(seed)));
    cmd(CODE_PAGE | 8'h03);
    cmd(8'h05);
    repeat (2) rd();
    tick(2);
    complete_run();
  end
endmodule
`default_nettype wire
